//--- bench/rcm_properties.sv
// Link checks for the rotary coordinate motion interface.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module rcm_properties
  import rcm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] cmd_data,
  input wire logic [31:0] first_rotary_coordinate,
  input wire logic [31:0] last_rotary_coordinate,
  input wire logic [31:0] origin_offset_setting,
  input wire logic cmd_ack,
  input wire logic data_setting_warning,
  input wire logic parameter_setting_alarm,
  input wire logic reference_done_flag,
  input wire logic [31:0] feedback_pos
);
  logic rot, out_d, chk_c, ofs_bad;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Range decode of command data and offset against the coordinates.
  assign rot = (first_rotary_coordinate | last_rotary_coordinate) !=
    32'h00000000;
  assign out_d = $signed(cmd_data) < $signed(first_rotary_coordinate) ||
    $signed(cmd_data) > $signed(last_rotary_coordinate);
  assign ofs_bad =
    $signed(origin_offset_setting) < $signed(first_rotary_coordinate) ||
    $signed(origin_offset_setting) > $signed(last_rotary_coordinate);
  assign chk_c = cmd_code inside {CMD_POS_SET, CMD_INTERP, CMD_POSITION,
    CMD_TRIG_POS};
  // A command that the range check refuses.
  sequence s_reject;
    cmd_valid && chk_c && rot && out_d;
  endsequence
  // Three cycles of linear motion with no command in between.
  sequence s_moving;
    (!reference_done_flag && !rot && !cmd_valid) [*3];
  endsequence
  a_ack_follows_cmd: assert property (cmd_valid |=> cmd_ack)
    else $error("command not acknowledged");
  a_ack_no_stray: assert property (cmd_ack |-> $past(cmd_valid))
    else $error("acknowledge without command");
  a_reject_warns: assert property (s_reject |=> data_setting_warning)
    else $error("out of range command not warned");
  a_reject_idle: assert property (s_reject and reference_done_flag
    |=> reference_done_flag && $stable(feedback_pos))
    else $error("refused command moved the axis");
  a_accept_clear: assert property (cmd_valid && !(chk_c && rot && out_d)
    |=> !data_setting_warning)
    else $error("accepted command left warning set");
  a_alarm_raised: assert property ((rot && ofs_bad) [*3]
    |-> parameter_setting_alarm)
    else $error("offset outside range without alarm");
  a_alarm_quiet: assert property ((!(rot && ofs_bad)) [*3]
    |-> !parameter_setting_alarm)
    else $error("alarm with offset inside range");
  a_idle_still: assert property (reference_done_flag &&
    $past(reference_done_flag) && !$past(cmd_valid)
    |-> $stable(feedback_pos))
    else $error("position moved while idle");
  a_step_unit: assert property (s_moving |-> feedback_pos -
    $past(feedback_pos) inside {32'h00000001, 32'hFFFFFFFF})
    else $error("linear move not one unit per cycle");
endmodule

//--- bench/rotary_coordinate_motion_test.sv
// Testbench joining host and axis ends over the link interface.
// Assumes the register port timing of the host end.
`timescale 1ns/10ps
module rotary_coordinate_motion_test
  import rcm_pkg::*;
;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, ext_trig = 0, rd_d = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, enc_pos = 32'h0, rnd = 32'h35A5, t;
  logic [31:0] reg_rdata, tab [7];
  logic motor_step, motor_fwd;
  logic [31:0] exp_q [$];
  int n_fail = 0, total_checks = 0, cyc = 0;
  rcm_if lnk();
  rcm_host rcm_host_i(.clk(clk), .rst_n(rst_n), .lnk(lnk),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  rcm_device rcm_device_i(.clk(clk), .rst_n(rst_n), .lnk(lnk),
    .enc_pos(enc_pos), .ext_trig(ext_trig), .motor_step(motor_step),
    .motor_fwd(motor_fwd));
  rcm_properties rcm_properties_i(.clk(clk), .rst_n(rst_n),
    .cmd_valid(lnk.cmd_valid), .cmd_code(lnk.cmd_code),
    .cmd_data(lnk.cmd_data),
    .first_rotary_coordinate(lnk.first_rotary_coordinate),
    .last_rotary_coordinate(lnk.last_rotary_coordinate),
    .origin_offset_setting(lnk.origin_offset_setting),
    .cmd_ack(lnk.cmd_ack), .data_setting_warning(lnk.data_setting_warning),
    .parameter_setting_alarm(lnk.parameter_setting_alarm),
    .reference_done_flag(lnk.reference_done_flag),
    .feedback_pos(lnk.feedback_pos));
  // Clock of 100 ns period.
  always #50 clk = ~clk;
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Read data is compared in the cycle after the read strobe.
  always @(posedge clk) begin
    if (rd_d) begin
      chk(exp_q.pop_front(), reg_rdata);
    end
    rd_d <= reg_rd;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c, input logic [31:0] d);
    wr(ADR_DATA, d);
    wr(ADR_CMD, {24'h0, c});
    repeat (3) @(posedge clk);
  endtask
  task automatic wait_done;
    for (int i = 0; i < 400 && lnk.reference_done_flag !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // Method, start, target and expected forward flag per entry.
  initial begin
    tab = '{32'h000A5A01, 32'h005A1400, 32'h010A5A00, 32'h025A1401,
      32'h030A5A00, 32'h035A1401, 32'h030A3C01};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADR_STATUS, 32'h00000001);
    rd(8'h40, 32'h0);
    wr(ADR_OFFSET, 32'h7FFFFFFF);
    rd(ADR_OFFSET, 32'h3FFFFFFF);
    wr(ADR_OFFSET, 32'hFFFFFFF9);
    enc_pos <= 32'h00000007;
    cmd(CMD_SENSOR_ON, 32'h0);
    rd(ADR_POS, 32'h0);
    cmd(CMD_POS_SET, 32'h00000064);
    cmd(CMD_POSITION, 32'hFFFFFFFB);
    wait_done();
    rd(ADR_POS, 32'hFFFFFFFB);
    $display("linear test done");
    wr(ADR_FIRST, 32'h0);
    wr(ADR_LAST, 32'h00000063);
    wr(ADR_OFFSET, 32'h000000C8);
    rd(ADR_STATUS, 32'h00000005);
    wr(ADR_OFFSET, 32'h00000005);
    cmd(CMD_SENSOR_ON, 32'h0);
    rd(ADR_POS, 32'h0000000C);
    wr(ADR_OFFSET, 32'h00000003);
    rd(ADR_POS, 32'h0000000C);
    cmd(CMD_SENSOR_ON, 32'h0);
    rd(ADR_POS, 32'h0000000A);
    $display("offset test done");
    foreach (tab[i]) begin
      wr(ADR_METHOD, {30'h0, tab[i][25:24]});
      cmd(CMD_POS_SET, {24'h0, tab[i][23:16]});
      cmd(CMD_POSITION, {24'h0, tab[i][15:8]});
      repeat (4) @(posedge clk);
      chk({31'h0, tab[i][0]}, {31'h0, motor_fwd});
      chk(32'h00000001, {31'h0, motor_step});
      wait_done();
      rd(ADR_POS, {24'h0, tab[i][15:8]});
    end
    $display("direction test done");
    foreach (tab[i]) begin
      cmd(tab[i][15:8] == 8'h5A ? CMD_INTERP : CMD_TRIG_POS, 32'h00000064);
      rd(ADR_STATUS, 32'h00000003);
      cmd(i[0] ? CMD_POS_SET : CMD_POSITION, 32'hFFFFFFFF);
      rd(ADR_STATUS, 32'h00000003);
    end
    rd(ADR_POS, {24'h0, tab[6][15:8]});
    $display("range test done");
    for (int i = 0; i < 3; i++) begin
      rnd = xs(rnd);
      t = rnd % 32'h00000064;
      cmd(i == 0 ? CMD_FEED : (i == 1 ? CMD_SPEED : CMD_TORQUE), 32'h200);
      rd(ADR_STATUS, 32'h0);
      cmd(CMD_POSITION, t);
      wait_done();
      rd(ADR_POS, t);
    end
    // Half a span away, so the move is still running at the status read.
    cmd(CMD_POSITION, (t + 32'h00000032) % 32'h00000064);
    wr(ADR_METHOD, 32'h00000001);
    rd(ADR_STATUS, 32'h00000008);
    wait_done();
    rd(ADR_STATUS, 32'h00000001);
    rd(ADR_METHOD, 32'h00000001);
    cmd(CMD_ORIGIN_RET, 32'h0);
    wait_done();
    rd(ADR_POS, 32'h0);
    $display("mode test done");
    // Feed starts at 0x0A and is at 0x0C when the trigger is sampled.
    // Target wraps once: 0x0C + 0x96 - 0x64 = 0x3E, moving forward.
    wr(ADR_FDIST, 32'h00000096);
    rd(ADR_FDIST, 32'h00000096);
    cmd(CMD_POS_SET, 32'h0000000A);
    cmd(CMD_TRIG_FEED, 32'h00000200);
    ext_trig <= 1'b1;
    @(posedge clk);
    ext_trig <= 1'b0;
    wait_done();
    rd(ADR_POS, 32'h0000003E);
    $display("trigger test done");
    repeat (3) @(posedge clk);
    test_done();
  end
endmodule

//--- rtl/rcm_device.sv
// Rotary axis logic: coordinate range, direction choice and motion.
// Assumes the host keeps settings stable and pulses cmd_valid one cycle.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/10ps
module rcm_device
  import rcm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  rcm_if.dev lnk,
  input wire logic [31:0] enc_pos,
  input wire logic ext_trig,
  output logic motor_step,
  output logic motor_fwd
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MOVE = 2'b01,
    ST_FEED = 2'b10
  } rcm_dev_st_e;

  typedef struct packed {
    rcm_dev_st_e st;
    logic [31:0] pos;
    logic [31:0] tgt;
    logic fwd;
    logic arm;
    logic ack;
    logic warn;
    logic alarm;
    logic step;
    logic done;
  } rcm_dev_s;

  // Reset state: idle, at coordinate zero, reference done.
  localparam rcm_dev_s DEV_RST = '{st: ST_IDLE, done: 1'b1, default: '0};

  rcm_dev_s s_r;
  rcm_dev_s s_nxt;

  logic signed [31:0] first_c;
  logic signed [31:0] last_c;
  logic rot;
  logic signed [33:0] span;

  // Rotary mode is active unless both range ends are zero.
  assign first_c = $signed(lnk.first_rotary_coordinate);
  assign last_c = $signed(lnk.last_rotary_coordinate);
  assign rot = (first_c != 32'sh0) || (last_c != 32'sh0);
  assign span = 34'(last_c) - 34'(first_c) + 34'sh1;

  // Folds a value once back into the range; one span correction only.
  function automatic logic [31:0] f_wrap(input logic signed [33:0] v);
    logic signed [33:0] w;
    w = v;
    if (rot && (w > 34'(last_c))) begin
      w = w - span;
    end else if (rot && (w < 34'(first_c))) begin
      w = w + span;
    end
    return w[31:0];
  endfunction

  // True when a value lies between first and last coordinates.
  function automatic logic f_in_rng(input logic [31:0] v);
    return !rot || (($signed(v) >= first_c) && ($signed(v) <= last_c));
  endfunction

  // Chooses the direction of travel from the position at this moment.
  function automatic logic f_dir(input logic [31:0] p, input logic [31:0] t);
    logic signed [33:0] fd;
    logic signed [33:0] rd;
    fd = 34'($signed(t)) - 34'($signed(p));
    if (fd < 34'sh0) begin
      fd = fd + span;
    end
    rd = span - fd;
    if (!rot) begin
      return $signed(t) > $signed(p);
    end
    case (rcm_meth_e'(lnk.rotary_move_method))
      METH_ABS: return $signed(t) > $signed(p);
      METH_REV: return 1'b0;
      METH_FWD: return 1'b1;
      METH_NEAR: return fd <= rd;
      default: return 1'b1;
    endcase
  endfunction

  // Command decode, range checks and one reference unit of motion a cycle.
  always_comb begin
    logic [31:0] dat;
    logic [31:0] trg_tgt;
    logic [31:0] nxt_pos;
    dat = lnk.cmd_data;
    trg_tgt = f_wrap(34'($signed(s_r.pos)) + 34'($signed(lnk.final_dist)));
    nxt_pos = s_r.fwd ? s_r.pos + ONE_32 : s_r.pos - ONE_32;
    if (rot && s_r.fwd && (s_r.pos == lnk.last_rotary_coordinate)) begin
      nxt_pos = lnk.first_rotary_coordinate;
    end else if (rot && !s_r.fwd &&
                 (s_r.pos == lnk.first_rotary_coordinate)) begin
      nxt_pos = lnk.last_rotary_coordinate;
    end
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    s_nxt.step = 1'b0;
    s_nxt.alarm = rot && !f_in_rng(lnk.origin_offset_setting);
    // Motion: a move ends on reaching the target, a feed runs on.
    case (s_r.st)
      ST_MOVE: begin
        if (s_r.pos == s_r.tgt) begin
          s_nxt.st = ST_IDLE;
        end else begin
          s_nxt.pos = nxt_pos;
          s_nxt.step = 1'b1;
        end
      end
      ST_FEED: begin
        s_nxt.pos = nxt_pos;
        s_nxt.step = 1'b1;
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    if (s_r.arm && ext_trig && (s_r.st != ST_IDLE)) begin
      s_nxt.arm = 1'b0;
      s_nxt.st = ST_MOVE;
      s_nxt.tgt = trg_tgt;
      s_nxt.fwd = !lnk.final_dist[POS_W-1];
    end
    // Accepted move, feed, origin and sensor-on commands override motion; a move takes its direction from pos now, a feed from the sign of the data.
    if (lnk.cmd_valid) begin
      s_nxt.ack = 1'b1;
      s_nxt.warn = 1'b0;
      case (lnk.cmd_code)
        CMD_POS_SET: begin
          if (f_in_rng(dat)) begin
            s_nxt.pos = dat;
          end else begin
            s_nxt.warn = 1'b1;
          end
        end
        CMD_SENSOR_ON: begin
          s_nxt.pos = f_wrap(34'($signed(enc_pos)) +
                             34'($signed(lnk.origin_offset_setting)));
          s_nxt.st = ST_IDLE;
          s_nxt.arm = 1'b0;
        end
        CMD_INTERP, CMD_POSITION, CMD_TRIG_POS: begin
          if (f_in_rng(dat)) begin
            s_nxt.fwd = f_dir(s_r.pos, dat);
            s_nxt.tgt = dat;
            s_nxt.st = ST_MOVE;
            s_nxt.arm = (lnk.cmd_code == CMD_TRIG_POS);
          end else begin
            s_nxt.warn = 1'b1;
          end
        end
        CMD_FEED, CMD_SPEED, CMD_TORQUE, CMD_TRIG_FEED: begin
          s_nxt.fwd = !dat[POS_W-1];
          s_nxt.st = ST_FEED;
          s_nxt.arm = (lnk.cmd_code == CMD_TRIG_FEED);
        end
        CMD_ORIGIN_RET: begin
          s_nxt.fwd = f_dir(s_r.pos, ZERO_32);
          s_nxt.tgt = ZERO_32;
          s_nxt.st = ST_MOVE;
          s_nxt.arm = 1'b0;
        end
        default: begin
          s_nxt.ack = 1'b1;
        end
      endcase
    end
    // Done flag is registered with the state so it leaves a flip-flop.
    s_nxt.done = (s_nxt.st == ST_IDLE);
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= DEV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Link and motor outputs, all straight from the state register.
  assign lnk.cmd_ack = s_r.ack;
  assign lnk.data_setting_warning = s_r.warn;
  assign lnk.parameter_setting_alarm = s_r.alarm;
  assign lnk.reference_done_flag = s_r.done;
  assign lnk.feedback_pos = s_r.pos;
  assign motor_step = s_r.step;
  assign motor_fwd = s_r.fwd;
endmodule

//--- rtl/rcm_host.sv
// Host end: software registers turned into settings and servo commands.
// Assumes the plain register port; read data one cycle after the strobe.
`timescale 1ns/10ps
module rcm_host
  import rcm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  rcm_if.host lnk,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] first;
    logic [31:0] last;
    logic [31:0] ofs;
    logic [31:0] fdist;
    logic [1:0] meth;
    logic [1:0] meth_pend;
    logic pend;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [31:0] rdata;
  } rcm_host_s;

  rcm_host_s s_r;
  rcm_host_s s_nxt;

  // Register writes, command issue and read mux.
  always_comb begin
    s_nxt = s_r;
    s_nxt.cmd_valid = 1'b0;
    s_nxt.rdata = ZERO_32;
    // Method only changed while reference done.
    if (s_r.pend && lnk.reference_done_flag) begin
      s_nxt.meth = s_r.meth_pend;
      s_nxt.pend = 1'b0;
    end
    if (reg_wr) begin
      case (reg_addr)
        ADR_DATA: s_nxt.data = reg_wdata;
        ADR_CMD: begin
          // Command and its data go out together.
          s_nxt.cmd_valid = 1'b1;
          s_nxt.cmd_code = reg_wdata[7:0];
        end
        ADR_FIRST: s_nxt.first = reg_wdata;
        ADR_LAST: s_nxt.last = reg_wdata;
        ADR_OFFSET: begin
          // Offset held within its legal range.
          if ($signed(reg_wdata) > OFS_MAX) begin
            s_nxt.ofs = OFS_MAX;
          end else if ($signed(reg_wdata) < OFS_MIN) begin
            s_nxt.ofs = OFS_MIN;
          end else begin
            s_nxt.ofs = reg_wdata;
          end
        end
        ADR_METHOD: begin
          s_nxt.meth_pend = reg_wdata[1:0];
          s_nxt.pend = 1'b1;
        end
        ADR_FDIST: s_nxt.fdist = reg_wdata;
        default: s_nxt.pend = s_r.pend;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        ADR_DATA: s_nxt.rdata = s_r.data;
        ADR_CMD: s_nxt.rdata = {24'h000000, s_r.cmd_code};
        ADR_FIRST: s_nxt.rdata = s_r.first;
        ADR_LAST: s_nxt.rdata = s_r.last;
        ADR_OFFSET: s_nxt.rdata = s_r.ofs;
        ADR_METHOD: s_nxt.rdata = {30'h0, s_r.meth};
        ADR_FDIST: s_nxt.rdata = s_r.fdist;
        ADR_STATUS: begin
          s_nxt.rdata[ST_DONE] = lnk.reference_done_flag;
          s_nxt.rdata[ST_WARN] = lnk.data_setting_warning;
          s_nxt.rdata[ST_ALARM] = lnk.parameter_setting_alarm;
          s_nxt.rdata[ST_PEND] = s_r.pend;
        end
        ADR_POS: s_nxt.rdata = lnk.feedback_pos;
        default: s_nxt.rdata = ZERO_32;
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Link outputs come straight from the state register.
  assign lnk.cmd_valid = s_r.cmd_valid;
  assign lnk.cmd_code = s_r.cmd_code;
  assign lnk.cmd_data = s_r.data;
  assign lnk.first_rotary_coordinate = s_r.first;
  assign lnk.last_rotary_coordinate = s_r.last;
  assign lnk.origin_offset_setting = s_r.ofs;
  assign lnk.final_dist = s_r.fdist;
  assign lnk.rotary_move_method = s_r.meth;
  assign reg_rdata = s_r.rdata;
endmodule

//--- rtl/rcm_if.sv
// Link between the host motion controller and the rotary axis logic.
// Assumes both ends share clk and rst_n; the testbench joins them.
`timescale 1ns/10ps
interface rcm_if;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [31:0] cmd_data;
  logic [31:0] first_rotary_coordinate;
  logic [31:0] last_rotary_coordinate;
  logic [31:0] origin_offset_setting;
  logic [31:0] final_dist;
  logic [1:0] rotary_move_method;
  logic cmd_ack;
  logic data_setting_warning;
  logic parameter_setting_alarm;
  logic reference_done_flag;
  logic [31:0] feedback_pos;
  modport dev (
    input cmd_valid, cmd_code, cmd_data, first_rotary_coordinate,
    input last_rotary_coordinate, origin_offset_setting, final_dist,
    input rotary_move_method,
    output cmd_ack, data_setting_warning, parameter_setting_alarm,
    output reference_done_flag, feedback_pos
  );
  modport host (
    output cmd_valid, cmd_code, cmd_data, first_rotary_coordinate,
    output last_rotary_coordinate, origin_offset_setting, final_dist,
    output rotary_move_method,
    input cmd_ack, data_setting_warning, parameter_setting_alarm,
    input reference_done_flag, feedback_pos
  );
endinterface

//--- rtl/rcm_pkg.sv
// Constants shared by both ends of the rotary coordinate motion link.
// Assumes a 10 MHz clock and 32-bit signed reference-unit positions.
package rcm_pkg;
  localparam int POS_W = 32;
  // Servo command codes carried on the link.
  localparam logic [7:0] CMD_POS_SET = 8'h20;
  localparam logic [7:0] CMD_SENSOR_ON = 8'h23;
  localparam logic [7:0] CMD_INTERP = 8'h34;
  localparam logic [7:0] CMD_POSITION = 8'h35;
  localparam logic [7:0] CMD_FEED = 8'h36;
  localparam logic [7:0] CMD_TRIG_FEED = 8'h37;
  localparam logic [7:0] CMD_TRIG_POS = 8'h39;
  localparam logic [7:0] CMD_ORIGIN_RET = 8'h3A;
  localparam logic [7:0] CMD_SPEED = 8'h3C;
  localparam logic [7:0] CMD_TORQUE = 8'h3D;
  // Movement method encodings.
  typedef enum logic [1:0] {
    METH_ABS = 2'b00,
    METH_REV = 2'b01,
    METH_FWD = 2'b10,
    METH_NEAR = 2'b11
  } rcm_meth_e;
  // Origin offset setting limits and the zero and one-unit constants.
  localparam logic signed [31:0] OFS_MAX = 32'sh3FFFFFFF;
  localparam logic signed [31:0] OFS_MIN = -32'sh3FFFFFFF;
  localparam logic [31:0] ZERO_32 = 32'h00000000;
  localparam logic [31:0] ONE_32 = 32'h00000001;
  // Host register byte addresses.
  localparam logic [7:0] ADR_DATA = 8'h00;
  localparam logic [7:0] ADR_CMD = 8'h04;
  localparam logic [7:0] ADR_FIRST = 8'h08;
  localparam logic [7:0] ADR_LAST = 8'h0C;
  localparam logic [7:0] ADR_OFFSET = 8'h10;
  localparam logic [7:0] ADR_METHOD = 8'h14;
  localparam logic [7:0] ADR_FDIST = 8'h18;
  localparam logic [7:0] ADR_STATUS = 8'h1C;
  localparam logic [7:0] ADR_POS = 8'h20;
  // Status register bit positions.
  localparam int ST_DONE = 0;
  localparam int ST_WARN = 1;
  localparam int ST_ALARM = 2;
  localparam int ST_PEND = 3;
endpackage
